// ---- core/hcs_cmd_status.sv ----
`timescale 1ns/1ps
// How it works
// - Each detected scheduling overrun outside a software reset adds one to the 2-bit count at bits 17:16.
// - Count resets to zero and wraps from three back to zero.
// - Count advances even while the overrun status flag is already set.
// - Setting ownership request raises the ownership changed status flag.
// - Ownership request clears after changeover and stays clear until rewritten.
// - At bulk head, zero skips the list; one starts processing and clears it.
// - Descriptor found on bulk list sets bulk filled again.
// - At control head, zero skips; one starts processing and clears it.
// - Descriptor found on control list sets control filled again.
// - Software reset forces suspend and resets registers, keeping interrupt routing.
// - No host bus access is started while the software reset runs.
// - Hardware clears the software reset bit when the reset is done.
// - Software reset completes within ten microseconds.
// - Software reset never resets the root hub nor signals downstream reset.
// - Writes are set-only; zeros keep bits, reads return all bits.
// - Periodic list unfinished at end of frame counts as overrun and sets flag.
module hcs_cmd_status
  import hcs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        periodic_overrun,
  input  wire logic        ownership_done,
  input  wire logic        bulk_head,
  input  wire logic        bulk_td_found,
  input  wire logic        ctrl_head,
  input  wire logic        ctrl_td_found,
  output logic             bulk_start,
  output logic             ctrl_start,
  output logic             sched_overrun_set,
  output logic             ownership_changed_set,
  output logic             suspend_force,
  output logic             oper_regs_reset,
  output logic             bus_access_block,
  output logic             swrst_done
);
  // ==========================================================
  // Decode
  function automatic logic hit(input logic [7:0] a);
    hit = (a == HCS_OFFSET);
  endfunction : hit

  logic       wr_hit;
  logic [1:0] soc_r;
  logic       own_req_r;
  logic       bulk_r;
  logic       ctrl_r;
  logic       swrst_r;
  hcs_state_t st_r;
  logic [HCS_RST_CW-1:0] cnt_r;

  assign wr_hit = reg_wr && hit(reg_addr);

  // ==========================================================
  // Overrun counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      soc_r <= HCS_SOC_RESET;
    else if (clk_en && st_r == HCS_RESETTING)
      soc_r <= HCS_SOC_RESET;
    else if (clk_en && periodic_overrun)
      soc_r <= soc_r + HCS_SOC_STEP;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sched_overrun_set <= 1'b0;
    else if (clk_en)
      sched_overrun_set <= periodic_overrun;
  end

  // ==========================================================
  // Ownership change
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      own_req_r             <= 1'b0;
      ownership_changed_set <= 1'b0;
    end
    else if (clk_en)
    begin
      ownership_changed_set <= wr_hit && reg_wdata[HCS_BIT_OWN_REQ];
      if (wr_hit && reg_wdata[HCS_BIT_OWN_REQ])
        own_req_r <= 1'b1;
      else if (ownership_done || st_r == HCS_RESETTING)
        own_req_r <= 1'b0;
    end
  end

  // ==========================================================
  // List filled flags
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bulk_r     <= 1'b0;
      ctrl_r     <= 1'b0;
      bulk_start <= 1'b0;
      ctrl_start <= 1'b0;
    end
    else if (clk_en)
    begin
      bulk_start <= bulk_head && bulk_r && st_r == HCS_IDLE;
      ctrl_start <= ctrl_head && ctrl_r && st_r == HCS_IDLE;
      if (wr_hit && reg_wdata[HCS_BIT_BULK_FILL])
        bulk_r <= 1'b1;
      else if (st_r == HCS_RESETTING)
        bulk_r <= 1'b0;
      else if (bulk_td_found)
        bulk_r <= 1'b1;
      else if (bulk_head)
        bulk_r <= 1'b0;
      if (wr_hit && reg_wdata[HCS_BIT_CTRL_FILL])
        ctrl_r <= 1'b1;
      else if (st_r == HCS_RESETTING)
        ctrl_r <= 1'b0;
      else if (ctrl_td_found)
        ctrl_r <= 1'b1;
      else if (ctrl_head)
        ctrl_r <= 1'b0;
    end
  end

  // ==========================================================
  // Software reset sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r    <= HCS_IDLE;
      cnt_r   <= '0;
      swrst_r <= 1'b0;
    end
    else if (clk_en)
    begin
      case (st_r)
        HCS_IDLE:
        begin
          cnt_r <= '0;
          if (wr_hit && reg_wdata[HCS_BIT_SWRST])
          begin
            swrst_r <= 1'b1;
            st_r    <= HCS_RESETTING;
          end
        end
        HCS_RESETTING:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == HCS_RST_LAST)
            st_r <= HCS_DONE;
        end
        HCS_DONE:
        begin
          swrst_r <= 1'b0;
          st_r    <= HCS_IDLE;
        end
        default: st_r <= HCS_IDLE;
      endcase
    end
  end

  // Root hub and port signalling are not touched here
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      suspend_force    <= 1'b0;
      oper_regs_reset  <= 1'b0;
      bus_access_block <= 1'b0;
      swrst_done       <= 1'b0;
    end
    else if (clk_en)
    begin
      suspend_force    <= (st_r == HCS_RESETTING);
      oper_regs_reset  <= (st_r == HCS_RESETTING);
      bus_access_block <= (st_r != HCS_IDLE) || (wr_hit && reg_wdata[HCS_BIT_SWRST]);
      swrst_done       <= (st_r == HCS_DONE);
    end
  end

  // ==========================================================
  // Read path
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= HCS_RESET_VALUE;
    else if (clk_en)
    begin
      reg_rdata <= HCS_RESET_VALUE;
      if (reg_rd && hit(reg_addr))
      begin
        reg_rdata[HCS_SOC_HI:HCS_SOC_LO] <= soc_r;
        reg_rdata[HCS_BIT_OWN_REQ]       <= own_req_r;
        reg_rdata[HCS_BIT_BULK_FILL]     <= bulk_r;
        reg_rdata[HCS_BIT_CTRL_FILL]     <= ctrl_r;
        reg_rdata[HCS_BIT_SWRST]         <= swrst_r;
      end
    end
  end

  // ==========================================================
  // Checks
  a_soc_increment: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && periodic_overrun && st_r != HCS_RESETTING |=> soc_r == $past(soc_r) + HCS_SOC_STEP)
    else $error("overrun count did not advance");
  a_soc_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && periodic_overrun && soc_r == 2'h3 && st_r != HCS_RESETTING |=> soc_r == 2'h0)
    else $error("overrun count did not wrap");
  a_soc_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && periodic_overrun |=> sched_overrun_set)
    else $error("overrun flag not raised");
  a_own_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_hit && reg_wdata[HCS_BIT_OWN_REQ] |=> ownership_changed_set && own_req_r)
    else $error("ownership flag not raised");
  a_own_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ownership_done && !wr_hit |=> !own_req_r)
    else $error("ownership request not cleared");
  a_bulk_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bulk_head && !bulk_r |=> !bulk_start)
    else $error("empty bulk list started");
  a_bulk_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bulk_head && wr_hit && reg_wdata[HCS_BIT_BULK_FILL] |=> bulk_r)
    else $error("bulk fill set lost");
  a_ctrl_refill: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ctrl_td_found && st_r == HCS_IDLE |=> ctrl_r)
    else $error("control fill not restored");
  a_swrst_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(swrst_r) |-> ##[1:40] !swrst_r)
    else $error("software reset too long");
  a_swrst_nobus: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_r == HCS_RESETTING |=> bus_access_block)
    else $error("bus not blocked in reset");
  c_overrun: cover property (@(posedge core_clk) periodic_overrun && soc_r == 2'h3);
  c_swrst: cover property (@(posedge core_clk) swrst_done);
  c_bulk: cover property (@(posedge core_clk) bulk_start);
  c_own: cover property (@(posedge core_clk) ownership_changed_set);
endmodule : hcs_cmd_status

// ---- core/hcs_pkg.sv ----
package hcs_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0]  HCS_OFFSET         = 8'h08;
  localparam logic [31:0] HCS_RESET_VALUE    = 32'h0000_0000;
  // ==========================================================
  // Field positions
  localparam int          HCS_BIT_SWRST      = 0;
  localparam int          HCS_BIT_CTRL_FILL  = 1;
  localparam int          HCS_BIT_BULK_FILL  = 2;
  localparam int          HCS_BIT_OWN_REQ    = 3;
  localparam int          HCS_SOC_LO         = 16;
  localparam int          HCS_SOC_HI         = 17;
  localparam int          HCS_IRQ_SO_BIT     = 0;
  localparam int          HCS_IRQ_OC_BIT     = 30;
  localparam int          HCS_CTRL_IR_BIT    = 8;
  localparam logic [1:0]  HCS_SOC_RESET      = 2'h0;
  localparam logic [1:0]  HCS_SOC_STEP       = 2'h1;
  // ==========================================================
  // Timing
  localparam int          HCS_CLK_MHZ        = 200;
  localparam int          HCS_RST_TIME_US    = 10;
  localparam int          HCS_RST_CYCLES     = HCS_RST_TIME_US * HCS_CLK_MHZ;
  localparam int          HCS_RST_CW         = 12;
  // Reset operation length, well inside the limit
  localparam logic [11:0] HCS_RST_LAST       = 12'h01f;
  // ==========================================================
  // Software reset sequencer
  typedef enum logic [1:0] {HCS_IDLE, HCS_RESETTING, HCS_DONE} hcs_state_t;
endpackage : hcs_pkg

// ---- tb/hcs_cmd_status_test.sv ----
`timescale 1ns/1ps
module hcs_cmd_status_test
  import hcs_pkg::*;
;
  // ========================================
  // Signals
  logic        core_clk, rst_n, clk_en, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic        periodic_overrun, ownership_done, bulk_head, bulk_td_found;
  logic        ctrl_head, ctrl_td_found, bulk_start, ctrl_start, sched_overrun_set;
  logic        ownership_changed_set, suspend_force, oper_regs_reset;
  logic        bus_access_block, swrst_done;
  int          num_errors, check_count, n;

  hcs_cmd_status i_hcs_cmd_status (.core_clk, .rst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .periodic_overrun, .ownership_done, .bulk_head, .bulk_td_found,
    .ctrl_head, .ctrl_td_found, .bulk_start, .ctrl_start, .sched_overrun_set,
    .ownership_changed_set, .suspend_force, .oper_regs_reset, .bus_access_block,
    .swrst_done);

  // ========================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    reg_rd = 1'b1; reg_addr = a;
    @(negedge core_clk);
    rv = reg_rdata;
    reg_rd = 1'b0;
  endtask : rd

  task automatic heads(input logic [31:0] d, input logic w);
    bulk_head = 1'b1; ctrl_head = 1'b1; reg_wr = w; reg_addr = HCS_OFFSET; reg_wdata = d;
    @(negedge core_clk);
    bulk_head = 1'b0; ctrl_head = 1'b0; reg_wr = 1'b0;
  endtask : heads

  // ========================================
  // Scenarios
  task automatic t_access;
    rd(HCS_OFFSET); chk("reset value", HCS_RESET_VALUE, rv);
    wr(8'h0c, 32'h8); rd(8'h0c); chk("unmapped read", 32'h0, rv);
    wr(HCS_OFFSET, 32'h4);
    wr(HCS_OFFSET, 32'h2);
    rd(HCS_OFFSET); chk("set-only write", 32'h6, rv);
    $display("test access done");
  endtask : t_access

  task automatic t_lists;
    heads(32'h0, 1'b0);
    chk("starts", 32'h3, {bulk_start, ctrl_start});
    rd(HCS_OFFSET); chk("filled cleared", 32'h0, rv);
    heads(32'h0, 1'b0);
    chk("skip lists", 32'h0, {bulk_start, ctrl_start});
    bulk_td_found = 1'b1; ctrl_td_found = 1'b1;
    @(negedge core_clk);
    bulk_td_found = 1'b0; ctrl_td_found = 1'b0;
    rd(HCS_OFFSET); chk("td re-set", 32'h6, rv);
    heads(32'h6, 1'b1);
    chk("starts again", 32'h3, {bulk_start, ctrl_start});
    rd(HCS_OFFSET); chk("set beats clear", 32'h6, rv);
    heads(32'h0, 1'b0);
    rd(HCS_OFFSET); chk("cleared again", 32'h0, rv);
    $display("test lists done");
  endtask : t_lists

  task automatic t_own;
    wr(HCS_OFFSET, 32'h8);
    chk("ownership changed", 32'h1, ownership_changed_set);
    rd(HCS_OFFSET); chk("request set", 32'h8, rv);
    ownership_done = 1'b1;
    @(negedge core_clk);
    ownership_done = 1'b0;
    rd(HCS_OFFSET); chk("request cleared", 32'h0, rv);
    rd(HCS_OFFSET); chk("request stays", 32'h0, rv);
    $display("test ownership done");
  endtask : t_own

  task automatic t_overrun;
    for (int i = 1; i <= 5; i++)
    begin
      periodic_overrun = 1'b1;
      @(negedge core_clk);
      periodic_overrun = 1'b0;
      chk("overrun flag", 32'h1, sched_overrun_set);
      rd(HCS_OFFSET); chk("overrun count", 32'(i % 4) << HCS_SOC_LO, rv);
    end
    clk_en = 1'b0; periodic_overrun = 1'b1;
    @(negedge core_clk);
    clk_en = 1'b1; periodic_overrun = 1'b0;
    rd(HCS_OFFSET); chk("count frozen", 32'h1 << HCS_SOC_LO, rv);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_swrst;
    wr(HCS_OFFSET, 32'h6);
    wr(HCS_OFFSET, 32'h1);
    @(negedge core_clk);
    chk("bus blocked", 32'h1, bus_access_block);
    chk("suspend", 32'h3, {suspend_force, oper_regs_reset});
    rd(HCS_OFFSET); chk("reset bit busy", 32'h1, rv);
    n = 0;
    while (swrst_done !== 1'b1 && n < 4000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("reset in time", 32'h1, 32'(n < HCS_RST_CYCLES));
    @(negedge core_clk);
    rd(HCS_OFFSET); chk("reset clears bits", 32'h0, rv);
    chk("bus free", 32'h0, bus_access_block);
    $display("test software reset done");
  endtask : t_swrst

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ========================================
  // Clock, watchdog, sequence
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #100us;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    num_errors = 0; check_count = 0;
    rst_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 32'h0; periodic_overrun = 1'b0;
    ownership_done = 1'b0; bulk_head = 1'b0; bulk_td_found = 1'b0;
    ctrl_head = 1'b0; ctrl_td_found = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    t_access();
    t_lists();
    t_own();
    t_overrun();
    t_swrst();
    report_and_stop();
  end
endmodule : hcs_cmd_status_test
